// *** include/pm_regs.svh ***
`ifndef PM_REGS_SVH
`define PM_REGS_SVH

// two-bit sub-state hint codes
`define PM_HINT_C1        2'h0
`define PM_HINT_C2        2'h1
`define PM_HINT_C3        2'h2
`define PM_HINT_DEEPEST   2'h3

// hint reset values for the two level-read registers
`define PM_HINT_TWO_RST   2'h1
`define PM_HINT_THREE_RST 2'h2

// hint write select
`define PM_HINT_SEL_TWO   1'b0
`define PM_HINT_SEL_THREE 1'b1

// chipset level-read request level
`define PM_LEVEL_TWO      1'b0
`define PM_LEVEL_THREE    1'b1

// synchroniser depth
`define PM_SYNC_STAGES    2

`endif

// *** include/pm_types_pkg.sv ***
`include "pm_regs.svh"

package pm_types_pkg;

    typedef enum logic [2:0] {
        CORE_C0,
        CORE_C1_HALT,
        CORE_C1_WAIT,
        CORE_C2,
        CORE_C3
    } core_state_t;

    typedef enum logic [2:0] {
        PKG_NORMAL,
        PKG_STOP_GRANT,
        PKG_STOP_GRANT_SNOOP,
        PKG_SLEEP,
        PKG_DEEP_SLEEP
    } pkg_state_t;

    // hint code to the low-power state it asks for; the spare code maps to the deepest
    function automatic core_state_t hint_to_state(input logic [1:0] hint);
        core_state_t s;
        s = CORE_C3;
        case (hint)
            `PM_HINT_C1: s = CORE_C1_WAIT;
            `PM_HINT_C2: s = CORE_C2;
            default:     s = CORE_C3;
        endcase
        return s;
    endfunction : hint_to_state

    // c1 halt and c1 wait count as one class for package resolution
    function automatic logic is_active_class(input core_state_t s);
        return (s == CORE_C0) || (s == CORE_C1_HALT) || (s == CORE_C1_WAIT);
    endfunction : is_active_class

endpackage : pm_types_pkg

// *** core/core_cstate_tracker.sv ***
`timescale 1ns/1ps

module core_cstate_tracker
    import pm_types_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // instruction requests
    input  wire logic        halt_req,
    input  wire logic        monitor_wait_req,
    input  wire logic [1:0]  monitor_wait_hint,
    input  wire logic        monitor_armed,
    input  wire logic        monitor_event,
    // level-read requests and their hints
    input  wire logic        level_read_req,
    input  wire logic        level_read_sel,
    input  wire logic [1:0]  hint_two,
    input  wire logic [1:0]  hint_three,
    // wake and stop clock
    input  wire logic        break_event,
    input  wire logic        stop_clock_active,
    // state out
    output core_state_t      state_q,
    output logic             stop_grant_ack_q
);

    logic       acked_q;
    logic [1:0] level_hint;

    assign level_hint = (level_read_sel == `PM_HINT_SEL_THREE) ? hint_three : hint_two;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= CORE_C0;
        end else if (state_q != CORE_C0) begin
            // wake has priority over any pending request
            if (break_event) begin
                state_q <= CORE_C0;
            end else if (monitor_event && state_q != CORE_C1_HALT) begin
                state_q <= CORE_C0;
            end
        end else if (level_read_req) begin
            // translated to a wait request; no monitor needed, no bus cycle made
            state_q <= hint_to_state(level_hint);
        end else if (monitor_wait_req && monitor_armed) begin
            state_q <= hint_to_state(monitor_wait_hint);
        end else if (halt_req) begin
            state_q <= CORE_C1_HALT;
        end
    end

    // one acknowledge per stop clock assertion and per stay in C2 or C3; a wake to C0 re-arms it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acked_q          <= 1'b0;
            stop_grant_ack_q <= 1'b0;
        end else begin
            stop_grant_ack_q <= 1'b0;
            if (!stop_clock_active || state_q == CORE_C0) begin
                acked_q <= 1'b0;
            end else if (!acked_q && (state_q == CORE_C2 || state_q == CORE_C3)) begin
                acked_q          <= 1'b1;
                stop_grant_ack_q <= 1'b1;
            end
        end
    end

endmodule : core_cstate_tracker

// *** core/package_state_resolver.sv ***
`timescale 1ns/1ps

module package_state_resolver
    import pm_types_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // core states
    input  core_state_t core0_state,
    input  core_state_t core1_state,
    input  wire logic   dual_core,
    // resolved target
    output pkg_state_t  resolved_q
);

    function automatic pkg_state_t resolve(input core_state_t a, input core_state_t b,
                                           input logic dual);
        pkg_state_t r;
        r = PKG_NORMAL;
        if (!dual) begin
            if (a == CORE_C2)
                r = PKG_STOP_GRANT;
            else if (a == CORE_C3)
                r = PKG_DEEP_SLEEP;
        end else if (is_active_class(a) || is_active_class(b)) begin
            r = PKG_NORMAL;
        end else if (a == CORE_C3 && b == CORE_C3) begin
            r = PKG_DEEP_SLEEP;
        end else begin
            r = PKG_STOP_GRANT;
        end
        return r;
    endfunction : resolve

    // recomputed every clock, so any core change shows one clock later
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            resolved_q <= PKG_NORMAL;
        else
            resolved_q <= resolve(core0_state, core1_state, dual_core);
    end

endmodule : package_state_resolver

// *** core/dual_core_power_state_coordinator.sv ***
`timescale 1ns/1ps

module dual_core_power_state_coordinator
    import pm_types_pkg::*;
#(
    parameter int NUM_CORES = 2
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // pins from the chipset, asynchronous
    input  wire logic        stop_clock_request_n,
    input  wire logic        sleep_request_n,
    input  wire logic        deep_sleep_request_n,
    input  wire logic        bus_snoop_n,
    input  wire logic        smi_n,
    input  wire logic        init_n,
    input  wire logic [1:0]  local_int,
    input  wire logic        core1_disable_strap,
    // bus interrupt messages, from bus logic on clk
    input  wire logic [1:0]  bus_interrupt_msg,
    // per-core instruction requests, on clk
    input  wire logic [1:0]  halt_req,
    input  wire logic [1:0]  monitor_wait_req,
    input  wire logic [3:0]  monitor_wait_hint,
    input  wire logic [1:0]  monitor_armed,
    input  wire logic [1:0]  monitor_event,
    // per-core level-read requests, on clk
    input  wire logic [1:0]  level_read_request,
    input  wire logic [1:0]  level_read_sel,
    // hint register write port, on clk
    input  wire logic        hint_wr_en,
    input  wire logic        hint_wr_sel,
    input  wire logic [1:0]  hint_wr_data,
    // chipset request
    output logic             chipset_level_req_q,
    output logic             chipset_level_sel_q,
    output logic [1:0]       stop_grant_ack_q,
    output logic             pending_break_event_n,
    // status
    output core_state_t      core0_state_q,
    output core_state_t      core1_state_q,
    output pkg_state_t       pkg_state_q,
    output logic [1:0]       hint_two_q,
    output logic [1:0]       hint_three_q
);

    localparam int PIN_W = 9;

    if (NUM_CORES != 2) begin : g_core_count_check
        $error("coordinator serves exactly two cores");
    end

    // pin synchroniser; first stage is read only by the second
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;

    assign pin_raw = {core1_disable_strap, local_int, init_n, smi_n, bus_snoop_n,
                      deep_sleep_request_n, sleep_request_n, stop_clock_request_n};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // active-low pins park high, local interrupts low: no false wake after reset
            pin_meta_q <= 9'h03f;
            pin_sync_q <= 9'h03f;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    // active-low pins are asserted when low
    logic       stop_clk;
    logic       sleep_req;
    logic       deep_req;
    logic       snoop;
    logic       pin_break;
    logic       strap_sync;

    assign stop_clk   = ~pin_sync_q[0];
    assign sleep_req  = ~pin_sync_q[1];
    assign deep_req   = ~pin_sync_q[2];
    assign snoop      = ~pin_sync_q[3];
    assign pin_break  = ~pin_sync_q[4] | ~pin_sync_q[5] | (|pin_sync_q[7:6]);
    assign strap_sync = pin_sync_q[8];

    // strap caught once the synchroniser has filled after reset release;
    // earlier edges would only see its parked reset value
    logic [1:0] strap_wait_q;
    logic       dual_core_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_wait_q <= 2'h0;
            dual_core_q  <= 1'b1;
        end else if (strap_wait_q != 2'h3) begin
            strap_wait_q <= strap_wait_q + 2'h1;
            dual_core_q  <= ~strap_sync;
        end
    end

    // level-read hint register, one hint per level-read register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hint_two_q   <= `PM_HINT_TWO_RST;
            hint_three_q <= `PM_HINT_THREE_RST;
        end else if (hint_wr_en) begin
            if (hint_wr_sel == `PM_HINT_SEL_THREE)
                hint_three_q <= hint_wr_data;
            else
                hint_two_q <= hint_wr_data;
        end
    end

    // break events per core: shared pins plus the core's own bus message
    logic [1:0] core_break;

    assign core_break[0] = pin_break | bus_interrupt_msg[0];
    assign core_break[1] = (pin_break | bus_interrupt_msg[1]) & dual_core_q;

    // a disabled core gets no requests and stays in C0
    logic [1:0] core_en;

    assign core_en = {dual_core_q, 1'b1};

    core_state_t core_state [2];
    logic [1:0]  ack_pulse;

    core_cstate_tracker u_core0 (
        .clk               (clk),
        .rst               (rst),
        .halt_req          (halt_req[0]),
        .monitor_wait_req  (monitor_wait_req[0]),
        .monitor_wait_hint (monitor_wait_hint[1:0]),
        .monitor_armed     (monitor_armed[0]),
        .monitor_event     (monitor_event[0]),
        .level_read_req    (level_read_request[0]),
        .level_read_sel    (level_read_sel[0]),
        .hint_two          (hint_two_q),
        .hint_three        (hint_three_q),
        .break_event       (core_break[0]),
        .stop_clock_active (stop_clk),
        .state_q           (core_state[0]),
        .stop_grant_ack_q  (ack_pulse[0])
    );

    core_cstate_tracker u_core1 (
        .clk               (clk),
        .rst               (rst),
        .halt_req          (halt_req[1] & core_en[1]),
        .monitor_wait_req  (monitor_wait_req[1] & core_en[1]),
        .monitor_wait_hint (monitor_wait_hint[3:2]),
        .monitor_armed     (monitor_armed[1]),
        .monitor_event     (monitor_event[1]),
        .level_read_req    (level_read_request[1] & core_en[1]),
        .level_read_sel    (level_read_sel[1]),
        .hint_two          (hint_two_q),
        .hint_three        (hint_three_q),
        .break_event       (core_break[1] | ~core_en[1]),
        .stop_clock_active (stop_clk),
        .state_q           (core_state[1]),
        .stop_grant_ack_q  (ack_pulse[1])
    );

    assign stop_grant_ack_q = ack_pulse;
    assign core0_state_q    = core_state[0];
    assign core1_state_q    = core_state[1];

    // resolved package target
    pkg_state_t resolved;
    pkg_state_t resolved_prev_q;

    package_state_resolver u_resolve (
        .clk         (clk),
        .rst         (rst),
        .core0_state (core_state[0]),
        .core1_state (core_state[1]),
        .dual_core   (dual_core_q),
        .resolved_q  (resolved)
    );

    // one chipset request per change into a low-power target
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resolved_prev_q     <= PKG_NORMAL;
            chipset_level_req_q <= 1'b0;
            chipset_level_sel_q <= `PM_LEVEL_TWO;
        end else begin
            resolved_prev_q     <= resolved;
            chipset_level_req_q <= 1'b0;
            if (resolved != resolved_prev_q) begin
                if (resolved == PKG_STOP_GRANT) begin
                    chipset_level_req_q <= 1'b1;
                    chipset_level_sel_q <= `PM_LEVEL_TWO;
                end else if (resolved == PKG_DEEP_SLEEP) begin
                    chipset_level_req_q <= 1'b1;
                    chipset_level_sel_q <= `PM_LEVEL_THREE;
                end
            end
        end
    end

    // package state machine, walked by the chipset pins
    pkg_state_t pkg_d;

    always_comb begin
        pkg_d = pkg_state_q;
        unique case (pkg_state_q)
            PKG_NORMAL: begin
                if (stop_clk)
                    pkg_d = PKG_STOP_GRANT;
            end
            PKG_STOP_GRANT: begin
                if (!stop_clk)
                    pkg_d = PKG_NORMAL;
                else if (sleep_req)
                    pkg_d = PKG_SLEEP;
                else if (snoop)
                    pkg_d = PKG_STOP_GRANT_SNOOP;
            end
            PKG_STOP_GRANT_SNOOP: begin
                // back once the snoop is serviced
                if (!snoop)
                    pkg_d = PKG_STOP_GRANT;
            end
            PKG_SLEEP: begin
                // snoops are not answered here; only the sleep pins move it
                if (deep_req)
                    pkg_d = PKG_DEEP_SLEEP;
                else if (!sleep_req)
                    pkg_d = PKG_STOP_GRANT;
            end
            PKG_DEEP_SLEEP: begin
                if (!deep_req)
                    pkg_d = PKG_SLEEP;
            end
            default: pkg_d = PKG_NORMAL;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            pkg_state_q <= PKG_NORMAL;
        else
            pkg_state_q <= pkg_d;
    end

    // pending break event: any core break while stop clock is asserted
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            pending_break_event_n <= 1'b1;
        else
            pending_break_event_n <= ~(stop_clk & (|core_break));
    end

endmodule : dual_core_power_state_coordinator

// *** verif/pm_coord_props.sv ***
`timescale 1ns/1ps
`include "pm_regs.svh"

module pm_coord_props
    import pm_types_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // inputs
    input wire logic       stop_clock_request_n,
    input wire logic       smi_n,
    input wire logic       init_n,
    input wire logic [1:0] local_int,
    input wire logic [1:0] bus_interrupt_msg,
    input wire logic [1:0] halt_req,
    input wire logic [1:0] monitor_wait_req,
    input wire logic [1:0] monitor_event,
    input wire logic [1:0] level_read_request,
    input wire logic [1:0] level_read_sel,
    // outputs
    input wire logic       chipset_level_req_q,
    input wire logic       chipset_level_sel_q,
    input wire logic [1:0] stop_grant_ack_q,
    input wire logic       pending_break_event_n,
    input core_state_t     core0_state_q,
    input pkg_state_t      pkg_state_q,
    input wire logic [1:0] hint_three_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // raw pins plus core0's bus message and monitor event; the synced copies lag, so keep wake pins idle around entries
    logic quiet0;
    assign quiet0 = smi_n && init_n && (local_int == 2'h0) && !bus_interrupt_msg[0]
                    && !monitor_event[0];

    sequence stop_fell_s;
        $fell(stop_clock_request_n) && (pkg_state_q == PKG_NORMAL)
            ##1 !stop_clock_request_n [*2];
    endsequence

    a_stop_to_grant: assert property (stop_fell_s |=> pkg_state_q == PKG_STOP_GRANT)
        else $error("stop clock did not give stop grant");
    a_break_needs_stop: assert property (
        !pending_break_event_n |-> !$past(stop_clock_request_n, 3))
        else $error("pending break low without stop clock");
    a_ack_needs_stop: assert property (
        (|stop_grant_ack_q) |-> !$past(stop_clock_request_n, 3))
        else $error("stop grant ack without stop clock");
    a_deep_needs_c3: assert property (
        chipset_level_req_q && chipset_level_sel_q |-> $past(core0_state_q, 2) == CORE_C3)
        else $error("level three request without core0 in c3");
    a_grant_sel_low: assert property (
        chipset_level_req_q && !chipset_level_sel_q
            |-> $past(core0_state_q, 2) inside {CORE_C2, CORE_C3})
        else $error("level two request with core0 active");
    a_level_read_c3: assert property (
        core0_state_q == CORE_C0 && level_read_request[0] && level_read_sel[0]
            && hint_three_q == `PM_HINT_C3 && quiet0 |=> core0_state_q == CORE_C3)
        else $error("level three read did not give c3");
    a_halt_entry_c1: assert property (
        core0_state_q == CORE_C0 && halt_req[0] && !monitor_wait_req[0] && !level_read_request[0]
            && quiet0 |=> core0_state_q == CORE_C1_HALT)
        else $error("halt did not give c1 halt");
    a_bus_int_wake: assert property (
        core0_state_q != CORE_C0 && bus_interrupt_msg[0] |=> core0_state_q == CORE_C0)
        else $error("bus interrupt did not wake core0");

    c_deep_request: cover property (chipset_level_req_q && chipset_level_sel_q);
    c_break_low: cover property ($fell(pending_break_event_n));
    c_ack_seen: cover property (|stop_grant_ack_q);
endmodule : pm_coord_props

bind dual_core_power_state_coordinator pm_coord_props u_props (
    .clk, .rst, .stop_clock_request_n, .smi_n, .init_n, .local_int, .bus_interrupt_msg,
    .halt_req, .monitor_wait_req, .monitor_event, .level_read_request, .level_read_sel,
    .chipset_level_req_q, .chipset_level_sel_q, .stop_grant_ack_q, .pending_break_event_n,
    .core0_state_q, .pkg_state_q, .hint_three_q
);

// *** verif/chipset_model.sv ***
`timescale 1ns/1ps

module chipset_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // bench command and processor outputs
    input  wire logic       stop_cmd,
    input  wire logic       pending_break_event_n,
    input  wire logic       chipset_level_req_q,
    input  wire logic       chipset_level_sel_q,
    input  wire logic [1:0] stop_grant_ack_q,
    // pin and what was seen
    output logic            stop_clock_request_n,
    output int              req_count,
    output int              ack_count,
    output logic            last_sel
);
    logic go;
    logic brk;

    initial begin
        stop_clock_request_n = 1'b1;
        req_count = 0;
        ack_count = 0;
        last_sel = 1'b0;
        forever begin
            @(posedge clk);
            go = stop_cmd;
            brk = (pending_break_event_n === 1'b0);
            if (chipset_level_req_q === 1'b1) begin
                req_count++;
                last_sel = chipset_level_sel_q;
            end
            if (|stop_grant_ack_q) begin
                ack_count++;
            end
            #1;
            // a pending break under stop clock means wake the whole package
            if (rst || brk) begin
                stop_clock_request_n = 1'b1;
            end else if (go) begin
                stop_clock_request_n = 1'b0;
            end
        end
    end
endmodule : chipset_model

// *** verif/test_dual_core_power_state_coordinator.sv ***
`timescale 1ns/1ps
`include "pm_regs.svh"

module test_dual_core_power_state_coordinator
    import pm_types_pkg::*;
();
    logic        clk, rst, stop_cmd, stop_n, smi_n, strap, hint_wr_en, hint_wr_sel;
    logic        req_q, sel_q, pend_n, last_sel, init_n, sleep_n;
    logic [1:0]  bus_msg, halt_req, wait_req, armed, mon_ev, lvl_req, lvl_sel;
    logic [1:0]  hint_d, ack_q, hint_two_q, hint_three_q;
    logic [3:0]  mw_hint;
    core_state_t c0_q, c1_q;
    pkg_state_t  pkg_q;
    int          num_errors, comparisons, req_count, ack_count, n;

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // deep sleep and snoop pins rest deasserted; local interrupts rest low
    dual_core_power_state_coordinator #(.NUM_CORES(2)) dut (
        .clk(clk), .rst(rst), .stop_clock_request_n(stop_n), .sleep_request_n(sleep_n),
        .deep_sleep_request_n(1'b1), .bus_snoop_n(1'b1), .smi_n(smi_n), .init_n(init_n),
        .local_int(2'h0), .core1_disable_strap(strap), .bus_interrupt_msg(bus_msg),
        .halt_req(halt_req), .monitor_wait_req(wait_req), .monitor_wait_hint(mw_hint),
        .monitor_armed(armed), .monitor_event(mon_ev), .level_read_request(lvl_req),
        .level_read_sel(lvl_sel), .hint_wr_en(hint_wr_en), .hint_wr_sel(hint_wr_sel),
        .hint_wr_data(hint_d), .chipset_level_req_q(req_q), .chipset_level_sel_q(sel_q),
        .stop_grant_ack_q(ack_q), .pending_break_event_n(pend_n), .core0_state_q(c0_q),
        .core1_state_q(c1_q), .pkg_state_q(pkg_q), .hint_two_q(hint_two_q),
        .hint_three_q(hint_three_q)
    );

    chipset_model chipset (
        .clk(clk), .rst(rst), .stop_cmd(stop_cmd), .pending_break_event_n(pend_n),
        .chipset_level_req_q(req_q), .chipset_level_sel_q(sel_q), .stop_grant_ack_q(ack_q),
        .stop_clock_request_n(stop_n), .req_count(req_count), .ack_count(ack_count),
        .last_sel(last_sel)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    task automatic lvl(input int c, input logic s);
        lvl_req[c] = 1'b1;
        lvl_sel[c] = s;
        step(1);
        lvl_req[c] = 1'b0;
    endtask : lvl

    task automatic wake(input int c);
        bus_msg[c] = 1'b1;
        step(1);
        bus_msg[c] = 1'b0;
    endtask : wake

    task automatic mw(input logic [1:0] h);
        mw_hint[1:0] = h;
        wait_req[0] = 1'b1;
        step(1);
        wait_req[0] = 1'b0;
    endtask : mw

    task automatic ev();
        mon_ev[0] = 1'b1;
        step(1);
        mon_ev[0] = 1'b0;
    endtask : ev

    // strap is set before reset so it is stable when latched
    task automatic do_reset(input logic s);
        strap = s;
        rst = 1'b1;
        step(12);
        rst = 1'b0;
        step(3);
    endtask : do_reset

    task automatic close_out();
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic t_reset();
        check("core0", c0_q, CORE_C0);
        check("core1", c1_q, CORE_C0);
        check("pkg", pkg_q, PKG_NORMAL);
        check("pend_n", pend_n, 1'b1);
        check("hint3", hint_three_q, `PM_HINT_THREE_RST);
    endtask : t_reset

    // monitor left unarmed throughout
    task automatic t_level();
        n = req_count;
        lvl(0, `PM_LEVEL_THREE);
        check("core0", c0_q, CORE_C3);
        lvl(1, `PM_LEVEL_TWO);
        check("core1", c1_q, CORE_C2);
        step(3);
        check("reqs", req_count - n, 1);
        check("sel", last_sel, `PM_LEVEL_TWO);
        wake(1);
        lvl(1, `PM_LEVEL_THREE);
        step(3);
        check("reqs", req_count - n, 2);
        check("sel", last_sel, `PM_LEVEL_THREE);
        wake(0);
        wake(1);
        step(3);
        check("reqs", req_count - n, 2);
        check("core0", c0_q, CORE_C0);
    endtask : t_level

    task automatic t_monitor_wait_instruction();
        mw(`PM_HINT_C1);
        check("core0", c0_q, CORE_C0);
        armed[0] = 1'b1;
        mw(`PM_HINT_C1);
        check("core0", c0_q, CORE_C1_WAIT);
        ev();
        check("core0", c0_q, CORE_C0);
        halt_req[0] = 1'b1;
        step(1);
        halt_req[0] = 1'b0;
        check("core0", c0_q, CORE_C1_HALT);
        ev();
        check("core0", c0_q, CORE_C1_HALT);
        init_n = 1'b0;
        step(3);
        check("core0", c0_q, CORE_C0);
        init_n = 1'b1;
        step(2);
        n = req_count;
        mw(`PM_HINT_C2);
        step(4);
        check("core0", c0_q, CORE_C2);
        check("core1", c1_q, CORE_C0);
        check("reqs", req_count - n, 0);
        check("acks", ack_count, 0);
    endtask : t_monitor_wait_instruction

    // core0 sits in c2 on entry
    task automatic t_stop();
        stop_cmd = 1'b1;
        step(1);
        stop_cmd = 1'b0;
        step(6);
        check("pkg", pkg_q, PKG_STOP_GRANT);
        check("acks", ack_count, 1);
        sleep_n = 1'b0;
        step(4);
        check("pkg", pkg_q, PKG_SLEEP);
        sleep_n = 1'b1;
        step(4);
        check("pkg", pkg_q, PKG_STOP_GRANT);
        smi_n = 1'b0;
        step(4);
        check("pend_n", pend_n, 1'b0);
        smi_n = 1'b1;
        step(8);
        check("pend_n", pend_n, 1'b1);
        check("pkg", pkg_q, PKG_NORMAL);
        check("core0", c0_q, CORE_C0);
    endtask : t_stop

    task automatic t_hint();
        hint_wr_en = 1'b1;
        hint_wr_sel = `PM_HINT_SEL_TWO;
        hint_d = `PM_HINT_C3;
        step(1);
        hint_wr_en = 1'b0;
        check("hint2", hint_two_q, `PM_HINT_C3);
        check("hint3", hint_three_q, `PM_HINT_THREE_RST);
        lvl(1, `PM_LEVEL_TWO);
        check("core1", c1_q, CORE_C3);
        wake(1);
    endtask : t_hint

    task automatic t_single();
        do_reset(1'b1);
        lvl(1, `PM_LEVEL_THREE);
        check("core1", c1_q, CORE_C0);
        n = req_count;
        lvl(0, `PM_LEVEL_TWO);
        step(3);
        check("reqs", req_count - n, 1);
        check("sel", last_sel, `PM_LEVEL_TWO);
        wake(0);
        lvl(0, `PM_LEVEL_THREE);
        step(3);
        check("reqs", req_count - n, 2);
        check("sel", last_sel, `PM_LEVEL_THREE);
    endtask : t_single

    initial begin
        num_errors = 0;
        comparisons = 0;
        {rst, smi_n, init_n, sleep_n} = 4'hf;
        {stop_cmd, strap, hint_wr_en, hint_wr_sel, hint_d} = '0;
        {bus_msg, halt_req, wait_req, armed, mon_ev, lvl_req, lvl_sel, mw_hint} = '0;
        do_reset(1'b0);
        t_reset();
        t_level();
        t_monitor_wait_instruction();
        t_stop();
        t_hint();
        t_single();
        close_out();
    end

    // the whole run needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        close_out();
    end
endmodule : test_dual_core_power_state_coordinator
